// >>> inc/pinmux_pkg.sv
/*
 * package for the pin function mux and strap capture block.
 * assumes: a single pclk domain, apb register access, 32 gpio pins.
 */
package pinmux_pkg;

    localparam int          GPIO_W          = 32;
    localparam int          RST_FIRST       = 6;
    localparam int          RST_LAST        = 20;
    localparam int          RST_N           = RST_LAST - RST_FIRST + 1;
    localparam int          EXP_FIRST       = 21;
    localparam int          EXP_LAST        = 28;
    localparam int          EXP_N           = EXP_LAST - EXP_FIRST + 1;
    localparam int          EXP10_PIN       = 31;
    localparam int          SYNC_STAGES     = 2;

    // management bus speed, the figures in khz
    localparam int          MGMT_SLOW_KHZ   = 100;
    localparam int          MGMT_FAST_KHZ   = 400;
    localparam int          SYS_CLK_KHZ     = 200000;
    localparam int          MGMT_SLOW_DIV   = SYS_CLK_KHZ / MGMT_SLOW_KHZ;
    localparam int          MGMT_FAST_DIV   = SYS_CLK_KHZ / MGMT_FAST_KHZ;
    localparam int          DIV_W           = 16;

    // lane widths of a port pair
    localparam logic [3:0]  WIDTH_X4        = 4'h4;
    localparam logic [3:0]  WIDTH_X8        = 4'h8;
    localparam logic [3:0]  WIDTH_NONE      = 4'h0;

    // register byte offsets
    localparam logic [11:0] OFS_ALTSEL      = 12'h000;
    localparam logic [11:0] OFS_GPIO_OUT    = 12'h004;
    localparam logic [11:0] OFS_GPIO_OE     = 12'h008;
    localparam logic [11:0] OFS_GPIO_IN     = 12'h00C;
    localparam logic [11:0] OFS_PORT_RST    = 12'h010;
    localparam logic [11:0] OFS_EXP_INT     = 12'h014;
    localparam logic [11:0] OFS_STRAPS      = 12'h018;

    localparam logic [31:0] ALTSEL_RESET    = 32'h0000_0000;
    localparam logic [31:0] GPIO_OUT_RESET  = 32'h0000_0000;
    localparam logic [31:0] GPIO_OE_RESET   = 32'h0000_0000;
    localparam logic [14:0] PORT_RST_RESET  = 15'h7FFF;

    // strap status field positions
    localparam int          ST_CCLK_DS      = 0;
    localparam int          ST_CCLK_US      = 1;
    localparam int          ST_MGMT_SLOW    = 2;
    localparam int          ST_PAIR01_MRG   = 3;
    localparam int          ST_PAIR23_MRG   = 4;

    typedef struct packed {
        logic downstream_common_clock;
        logic upstream_common_clock;
        logic mgmt_slow;
        logic pair01_merged;
        logic pair23_merged;
    } strap_cfg_t;

    typedef struct packed {
        logic [3:0] port0_width;
        logic [3:0] port1_width;
        logic [3:0] port2_width;
        logic [3:0] port3_width;
    } lane_cfg_t;

endpackage

// >>> rtl/sync2.sv
/*
 * two flop synchroniser for one level.
 * assumes: the input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level
    input  wire logic d,
    output logic      q
);
    logic meta_ff;
    logic q_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RESET_VAL;
            q_ff    <= RESET_VAL;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// >>> rtl/mgmt_tick_gen.sv
/*
 * bit rate tick for the master management bus, speed set by a frozen strap.
 * assumes: slow is stable after reset capture; no software path reaches it.
 */
`timescale 1ns/1ps
`default_nettype none
module mgmt_tick_gen
    import pinmux_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // speed select
    input  wire logic slow,
    output logic      tick
);
    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic             tick_ff;
    logic             nxt_tick;
    logic [DIV_W-1:0] limit;

    always_comb begin
        limit    = slow ? DIV_W'(MGMT_SLOW_DIV - 1) : DIV_W'(MGMT_FAST_DIV - 1);
        nxt_tick = (cnt_ff >= limit);
        nxt_cnt  = nxt_tick ? '0 : cnt_ff + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule
`default_nettype wire

// >>> rtl/pinmux_strap.sv
/*
 * gpio alternate function mux and system strap capture.
 * assumes: pins and straps are asynchronous to pclk; apb master on pclk;
 * the pad ring resolves each gpio from its out and active low enable.
 */
// Notes on behaviour
// - unselected pins work as plain gpio
// - pins 6..20 drive port 1..15 resets
// - pins 21..28 take expander 0..7 interrupts
// - pin 31 takes expander 10 interrupt
// - downstream strap marks downstream links common-clocked
// - upstream strap marks upstream link common-clocked
// - slow strap gives 100 KHz, else 400
// - bus speed has no software override
// - pair01 strap low merges into x8
// - pair01 strap high keeps two x4
// - pair23 strap low merges into x8
// - pair23 strap high keeps two x4
// - merge straps active low, pulled low
`timescale 1ns/1ps
`default_nettype none
module pinmux_strap
    import pinmux_pkg::*;
(
    // apb
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // gpio pads
    input  wire logic [GPIO_W-1:0] gpio_in,
    output logic [GPIO_W-1:0]      gpio_out,
    output logic [GPIO_W-1:0]      gpio_oe_n,
    // straps
    input  wire logic              downstream_common_clock_strap,
    input  wire logic              upstream_common_clock_strap,
    input  wire logic              master_mgmt_bus_slow_strap,
    input  wire logic              pair01_merge_strap_n,
    input  wire logic              pair23_merge_strap_n,
    // to the switch core
    output strap_cfg_t             strap_cfg,
    output lane_cfg_t              lane_cfg,
    output logic [EXP_N-1:0]       expander_interrupt_n,
    output logic                   expander10_interrupt_n,
    output logic                   mgmt_bit_tick
);
    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    logic [GPIO_W-1:0] pin_sync;
    logic [4:0]        strap_sync;
    logic [4:0]        strap_raw;

    assign strap_raw = {pair23_merge_strap_n, pair01_merge_strap_n,
                        master_mgmt_bus_slow_strap, upstream_common_clock_strap,
                        downstream_common_clock_strap};

    // pins idle high so expander interrupts read inactive during reset
    for (genvar i = 0; i < GPIO_W; i++) begin : g_pin_sync
        sync2 #(.RESET_VAL(1'b1)) u_sync (
            .clk   (pclk),
            .rst_n (presetn),
            .d     (gpio_in[i]),
            .q     (pin_sync[i])
        );
    end

    for (genvar i = 0; i < 5; i++) begin : g_strap_sync
        sync2 #(.RESET_VAL(1'b0)) u_sync (
            .clk   (pclk),
            .rst_n (presetn),
            .d     (strap_raw[i]),
            .q     (strap_sync[i])
        );
    end

    // -----------------------------------------------------------------
    // strap capture
    // -----------------------------------------------------------------
    // the sampled strap is captured on the third edge after release,
    // once the synchronisers carry the real pin level, then frozen.
    logic [1:0] cap_cnt_ff;
    logic [1:0] nxt_cap_cnt;
    logic       captured_ff;
    logic       nxt_captured;
    strap_cfg_t strap_ff;
    strap_cfg_t nxt_strap;
    lane_cfg_t  lane_ff;
    lane_cfg_t  nxt_lane;

    always_comb begin
        nxt_cap_cnt  = cap_cnt_ff;
        nxt_captured = captured_ff;
        nxt_strap    = strap_ff;
        nxt_lane     = lane_ff;
        if (!captured_ff) begin
            nxt_cap_cnt = cap_cnt_ff + 1'b1;
            if (cap_cnt_ff == 2'(SYNC_STAGES)) begin
                nxt_captured = 1'b1;
                nxt_strap.downstream_common_clock = strap_sync[ST_CCLK_DS];
                nxt_strap.upstream_common_clock   = strap_sync[ST_CCLK_US];
                nxt_strap.mgmt_slow               = strap_sync[ST_MGMT_SLOW];
                nxt_strap.pair01_merged           = !strap_sync[ST_PAIR01_MRG];
                nxt_strap.pair23_merged           = !strap_sync[ST_PAIR23_MRG];
                if (!strap_sync[ST_PAIR01_MRG]) begin
                    nxt_lane.port0_width = WIDTH_X8;
                    nxt_lane.port1_width = WIDTH_NONE;
                end else begin
                    nxt_lane.port0_width = WIDTH_X4;
                    nxt_lane.port1_width = WIDTH_X4;
                end
                if (!strap_sync[ST_PAIR23_MRG]) begin
                    nxt_lane.port2_width = WIDTH_X8;
                    nxt_lane.port3_width = WIDTH_NONE;
                end else begin
                    nxt_lane.port2_width = WIDTH_X4;
                    nxt_lane.port3_width = WIDTH_X4;
                end
            end
        end
    end

    // reset value matches an unstrapped board: merge pins pulled low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cnt_ff  <= '0;
            captured_ff <= 1'b0;
            strap_ff    <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
            lane_ff     <= '{WIDTH_X8, WIDTH_NONE, WIDTH_X8, WIDTH_NONE};
        end else begin
            cap_cnt_ff  <= nxt_cap_cnt;
            captured_ff <= nxt_captured;
            strap_ff    <= nxt_strap;
            lane_ff     <= nxt_lane;
        end
    end

    // -----------------------------------------------------------------
    // registers and apb slave
    // -----------------------------------------------------------------
    logic [31:0]      altsel_ff;
    logic [31:0]      nxt_altsel;
    logic [31:0]      gpo_ff;
    logic [31:0]      nxt_gpo;
    logic [31:0]      gpoe_ff;
    logic [31:0]      nxt_gpoe;
    logic [RST_N-1:0] port_rst_ff;
    logic [RST_N-1:0] nxt_port_rst;
    logic [31:0]      prdata_ff;
    logic [31:0]      nxt_prdata;
    logic             pslverr_ff;
    logic             nxt_pslverr;
    logic             pready_ff;
    logic             nxt_pready;
    logic             wr;
    logic             rd;

    // one wait state: pready rises in the second access cycle, so every
    // transfer takes setup plus two access cycles.
    always_comb begin
        nxt_altsel   = altsel_ff;
        nxt_gpo      = gpo_ff;
        nxt_gpoe     = gpoe_ff;
        nxt_port_rst = port_rst_ff;
        nxt_prdata   = prdata_ff;
        nxt_pslverr  = 1'b0;
        nxt_pready   = psel && penable && !pready_ff;
        wr           = nxt_pready && pwrite;
        rd           = nxt_pready && !pwrite;
        if (nxt_pready) begin
            nxt_prdata = 32'h0000_0000;
            if (paddr == OFS_ALTSEL) begin
                if (wr) nxt_altsel = pwdata;
                nxt_prdata = altsel_ff;
            end else if (paddr == OFS_GPIO_OUT) begin
                if (wr) nxt_gpo = pwdata;
                nxt_prdata = gpo_ff;
            end else if (paddr == OFS_GPIO_OE) begin
                if (wr) nxt_gpoe = pwdata;
                nxt_prdata = gpoe_ff;
            end else if (paddr == OFS_GPIO_IN) begin
                nxt_prdata = pin_sync;
            end else if (paddr == OFS_PORT_RST) begin
                if (wr) nxt_port_rst = pwdata[RST_N-1:0];
                nxt_prdata = {17'h0_0000, port_rst_ff};
            end else if (paddr == OFS_EXP_INT) begin
                nxt_prdata = {23'h00_0000, expander10_interrupt_n,
                              pin_sync[EXP_LAST:EXP_FIRST]};
            end else if (paddr == OFS_STRAPS) begin
                // read only: the slow strap cannot be overwritten
                nxt_prdata = {27'h000_0000, strap_ff.pair23_merged, strap_ff.pair01_merged,
                              strap_ff.mgmt_slow, strap_ff.upstream_common_clock,
                              strap_ff.downstream_common_clock};
            end else begin
                nxt_pslverr = 1'b1;
            end
            if (!rd) nxt_prdata = prdata_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            altsel_ff   <= ALTSEL_RESET;
            gpo_ff      <= GPIO_OUT_RESET;
            gpoe_ff     <= GPIO_OE_RESET;
            port_rst_ff <= PORT_RST_RESET;
            prdata_ff   <= 32'h0000_0000;
            pslverr_ff  <= 1'b0;
            pready_ff   <= 1'b0;
        end else begin
            altsel_ff   <= nxt_altsel;
            gpo_ff      <= nxt_gpo;
            gpoe_ff     <= nxt_gpoe;
            port_rst_ff <= nxt_port_rst;
            prdata_ff   <= nxt_prdata;
            pslverr_ff  <= nxt_pslverr;
            pready_ff   <= nxt_pready;
        end
    end

    // -----------------------------------------------------------------
    // pin mux
    // -----------------------------------------------------------------
    logic [GPIO_W-1:0] nxt_pin_out;
    logic [GPIO_W-1:0] nxt_pin_oe_n;
    logic [GPIO_W-1:0] pin_out_ff;
    logic [GPIO_W-1:0] pin_oe_n_ff;
    logic [EXP_N-1:0]  nxt_exp;
    logic [EXP_N-1:0]  exp_ff;
    logic              nxt_exp10;
    logic              exp10_ff;

    always_comb begin
        nxt_pin_out  = gpo_ff;
        nxt_pin_oe_n = ~gpoe_ff;
        nxt_exp      = {EXP_N{1'b1}};
        nxt_exp10    = 1'b1;
        for (int p = 0; p < RST_N; p++) begin
            if (altsel_ff[RST_FIRST + p]) begin
                // port n reset is active low on pin RST_FIRST+n-1
                nxt_pin_out[RST_FIRST + p]  = !port_rst_ff[p];
                nxt_pin_oe_n[RST_FIRST + p] = 1'b0;
            end
        end
        for (int e = 0; e < EXP_N; e++) begin
            if (altsel_ff[EXP_FIRST + e]) begin
                nxt_pin_oe_n[EXP_FIRST + e] = 1'b1;
                nxt_exp[e] = pin_sync[EXP_FIRST + e];
            end
        end
        if (altsel_ff[EXP10_PIN]) begin
            nxt_pin_oe_n[EXP10_PIN] = 1'b1;
            nxt_exp10 = pin_sync[EXP10_PIN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff  <= '0;
            pin_oe_n_ff <= '1;
            exp_ff      <= '1;
            exp10_ff    <= 1'b1;
        end else begin
            pin_out_ff  <= nxt_pin_out;
            pin_oe_n_ff <= nxt_pin_oe_n;
            exp_ff      <= nxt_exp;
            exp10_ff    <= nxt_exp10;
        end
    end

    // -----------------------------------------------------------------
    // management bus rate
    // -----------------------------------------------------------------
    mgmt_tick_gen u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .slow    (strap_ff.mgmt_slow),
        .tick    (mgmt_bit_tick)
    );

    assign pready                 = pready_ff;
    assign pslverr                = pslverr_ff;
    assign prdata                 = prdata_ff;
    assign gpio_out               = pin_out_ff;
    assign gpio_oe_n              = pin_oe_n_ff;
    assign strap_cfg              = strap_ff;
    assign lane_cfg               = lane_ff;
    assign expander_interrupt_n   = exp_ff;
    assign expander10_interrupt_n = exp10_ff;
endmodule
`default_nettype wire

// >>> tb/pinmux_strap_assertions.sv
/*
 * concurrent checks on the pin mux and strap capture block.
 * assumes: bound to pinmux_strap, one pclk domain, async active low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pinmux_strap_checker
    import pinmux_pkg::*;
(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    // pads and straps
    input wire logic [GPIO_W-1:0] gpio_in,
    input wire logic              downstream_common_clock_strap,
    input wire logic              upstream_common_clock_strap,
    input wire logic              master_mgmt_bus_slow_strap,
    input wire logic              pair01_merge_strap_n,
    input wire logic              pair23_merge_strap_n,
    // core side
    input wire strap_cfg_t        strap_cfg,
    input wire lane_cfg_t         lane_cfg,
    input wire logic [EXP_N-1:0]  expander_interrupt_n,
    input wire logic              expander10_interrupt_n,
    input wire logic              mgmt_bit_tick
);
    // ----
    // edges since release, tick spacing
    // ----
    logic [2:0]  cnt_ff, nxt_cnt;
    logic [11:0] gap_ff, nxt_gap, lim;
    logic        armed_ff, nxt_armed;

    // only ticks after the capture count: the speed may switch at capture
    always_comb begin
        nxt_cnt   = (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
        nxt_gap   = mgmt_bit_tick ? 12'h001 : gap_ff + 12'h001;
        nxt_armed = (cnt_ff == 3'h7) && (armed_ff || mgmt_bit_tick);
        lim       = strap_cfg.mgmt_slow ? 12'(MGMT_SLOW_DIV) : 12'(MGMT_FAST_DIV);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff   <= 3'h0;
            gap_ff   <= 12'h000;
            armed_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            gap_ff   <= nxt_gap;
            armed_ff <= nxt_armed;
        end
    end

    // ----
    // properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable && !pready;
    endsequence

    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_apb_answer: assert property (s_access |=> s_answer)
        else $error("apb answer not one wait state and one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_clock_straps: assert property (cnt_ff == 3'h3 |->
        strap_cfg.downstream_common_clock == downstream_common_clock_strap &&
        strap_cfg.upstream_common_clock == upstream_common_clock_strap &&
        strap_cfg.mgmt_slow == master_mgmt_bus_slow_strap)
        else $error("clock or speed strap captured wrong");
    a_merge_low: assert property (cnt_ff == 3'h3 |->
        strap_cfg.pair01_merged == !pair01_merge_strap_n &&
        strap_cfg.pair23_merged == !pair23_merge_strap_n)
        else $error("merge strap polarity wrong");
    a_cfg_frozen: assert property (cnt_ff == 3'h7 |->
        $stable(strap_cfg) && $stable(lane_cfg))
        else $error("strap config changed after capture");
    a_lanes_pair01: assert property ({lane_cfg.port0_width, lane_cfg.port1_width} ==
        (strap_cfg.pair01_merged ? {WIDTH_X8, WIDTH_NONE} : {WIDTH_X4, WIDTH_X4}))
        else $error("pair01 lane widths wrong");
    a_lanes_pair23: assert property ({lane_cfg.port2_width, lane_cfg.port3_width} ==
        (strap_cfg.pair23_merged ? {WIDTH_X8, WIDTH_NONE} : {WIDTH_X4, WIDTH_X4}))
        else $error("pair23 lane widths wrong");
    a_tick_spacing: assert property (armed_ff |->
        gap_ff <= lim && (!mgmt_bit_tick || gap_ff == lim))
        else $error("bus tick spacing wrong");
    a_exp_from_pins: assert property (
        (~expander_interrupt_n & $past(gpio_in[28:21], 3)) == 8'h00)
        else $error("expander interrupt low without pin low");
    a_exp10_from_pin: assert property (
        !expander10_interrupt_n |-> !$past(gpio_in[31], 3))
        else $error("expander 10 interrupt low without pin low");
endmodule

bind pinmux_strap pinmux_strap_checker u_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
    .downstream_common_clock_strap(downstream_common_clock_strap),
    .upstream_common_clock_strap(upstream_common_clock_strap),
    .master_mgmt_bus_slow_strap(master_mgmt_bus_slow_strap),
    .pair01_merge_strap_n(pair01_merge_strap_n), .pair23_merge_strap_n(pair23_merge_strap_n),
    .strap_cfg(strap_cfg), .lane_cfg(lane_cfg), .expander_interrupt_n(expander_interrupt_n),
    .expander10_interrupt_n(expander10_interrupt_n), .mgmt_bit_tick(mgmt_bit_tick)
);
`default_nettype wire

// >>> tb/board_model.sv
/*
 * board model: strap resistors, pad resolution and expander interrupt drivers.
 * assumes: the bench sets strap levels before it releases reset.
 */
`timescale 1ns/1ps
`default_nettype none
module board_model (
    // clock
    input  wire logic        pclk,
    // block pads
    input  wire logic [31:0] gpio_out,
    input  wire logic [31:0] gpio_oe_n,
    // bench commands
    input  wire logic [31:0] ext_val,
    input  wire logic [31:0] ext_en,
    input  wire logic [4:0]  strap_val,
    input  wire logic [1:0]  merge_en,
    // to the block
    output logic [31:0]      gpio_in,
    output logic [4:0]       straps
);
    // an open pad must not look like a steady level
    logic [31:0] float_ff = 32'h5555_AAAA;

    always_ff @(posedge pclk) begin
        float_ff <= ~float_ff;
    end

    // expanders drive their interrupt pins only while the block does not
    assign gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & ext_en & ext_val)
                   | (gpio_oe_n & ~ext_en & float_ff);
    assign straps[4:2] = strap_val[4:2];
    // an open merge strap falls to the internal pull-down
    assign straps[1] = merge_en[1] & strap_val[1];
    assign straps[0] = merge_en[0] & strap_val[0];
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * self-checking bench for the pin mux and strap block.
 * assumes: board_model on the pads and straps, checker bound to the block.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pinmux_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic        exp10_n, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, gpio_in, gpio_out, gpio_oe_n, ext_val, ext_en, last_rd;
    logic [4:0]  strap_val, straps;
    logic [1:0]  merge_en;
    logic [7:0]  exp_n;
    strap_cfg_t  strap_cfg;
    lane_cfg_t   lane_cfg;
    int          failures, n_checks;

    pinmux_strap dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .downstream_common_clock_strap(straps[4]), .upstream_common_clock_strap(straps[3]),
        .master_mgmt_bus_slow_strap(straps[2]), .pair01_merge_strap_n(straps[1]),
        .pair23_merge_strap_n(straps[0]), .strap_cfg(strap_cfg), .lane_cfg(lane_cfg),
        .expander_interrupt_n(exp_n), .expander10_interrupt_n(exp10_n), .mgmt_bit_tick(tick)
    );

    board_model board (
        .pclk(pclk), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .ext_val(ext_val),
        .ext_en(ext_en), .strap_val(strap_val), .merge_en(merge_en), .gpio_in(gpio_in),
        .straps(straps)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----
    // tasks
    // ----
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // idle cycle first, so psel never changes twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            failures++;
            $display("[ERR] %0t apb timeout", $time);
            wrap_up;
        end else begin
            last_rd  = prdata;
            last_err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0000_0000);
        check(last_rd & m, exp, "read");
    endtask

    task automatic do_reset(input logic [4:0] sv, input logic [1:0] me);
        presetn   <= 1'b0;
        strap_val <= sv;
        merge_en  <= me;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask

    task automatic tick_gap(input int exp);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (tick !== 1'b1 && k < 3000);
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (tick !== 1'b1 && k < 3000);
        if (tick !== 1'b1) begin
            failures++;
            $display("[ERR] %0t tick timeout", $time);
            wrap_up;
        end else begin
            check(k, exp, "tick gap");
        end
    endtask

    // ----
    // sequence
    // ----
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {failures, n_checks} = '0;
        ext_val = 32'h14A0_0001;
        ext_en  = 32'h9FE0_0003;
        do_reset(5'b10001, 2'b01);
        check(32'(strap_cfg), 32'h0000_0012, "strap cfg");
        check(32'(lane_cfg), 32'h0000_8044, "lanes");
        rd_chk(OFS_STRAPS, 32'h0000_0009, 32'h0000_001F);
        strap_val <= 5'b01110;
        merge_en  <= 2'b11;
        apb(1'b1, OFS_STRAPS, 32'hFFFF_FFFF);
        rd_chk(OFS_STRAPS, 32'h0000_0009, 32'h0000_001F);
        tick_gap(MGMT_FAST_DIV);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check(32'(last_err), 32'h0000_0001, "unmapped err");
        check(last_rd, 32'h0000_0000, "unmapped data");
        apb(1'b1, OFS_GPIO_OE, 32'h6000_0000);
        apb(1'b1, OFS_GPIO_OUT, 32'h4000_0000);
        repeat (2) @(posedge pclk);
        check(32'({gpio_oe_n[30:29], gpio_out[30:29]}), 32'h0000_0002, "plain pins");
        rd_chk(OFS_GPIO_IN, 32'h4000_0001, 32'h6000_0003);
        rd_chk(OFS_PORT_RST, 32'h0000_7FFF, 32'h0000_7FFF);
        apb(1'b1, OFS_ALTSEL, 32'h9FFF_FFC0);
        apb(1'b1, OFS_PORT_RST, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        check(32'({gpio_oe_n[20:6], gpio_out[20:6]}), 32'h0000_7FFE, "port resets");
        check(32'({gpio_oe_n[31], gpio_oe_n[28:21], exp10_n, exp_n}), 32'h0003_FEA5, "exp");
        rd_chk(OFS_EXP_INT, 32'h0000_00A5, 32'h0000_01FF);
        ext_val <= 32'h8B40_0001;
        repeat (5) @(posedge pclk);
        check(32'({exp10_n, exp_n}), 32'h0000_015A, "exp change");
        do_reset(5'b01110, 2'b11);
        check(32'(strap_cfg), 32'h0000_000D, "strap cfg");
        check(32'(lane_cfg), 32'h0000_4480, "lanes");
        rd_chk(OFS_STRAPS, 32'h0000_0016, 32'h0000_001F);
        rd_chk(OFS_ALTSEL, 32'h0000_0000, 32'hFFFF_FFFF);
        tick_gap(MGMT_SLOW_DIV);
        wrap_up;
    end
endmodule
`default_nettype wire
